// [rtl/dma_stream_pkg.sv]
// Shared constants and types of the single-stream transfer controller
package dma_stream_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int DATA_W = 32;
   localparam int ADDR_W = 32;
   localparam int CNT_W = 16;
   localparam int FIFO_DEPTH = 4;
   localparam int LVL_W = 3;
   localparam int PTR_W = 2;
   localparam int FLAG_W = 2;

   // ----------------------------------------------------------------
   // Transfer modes, flag positions, reset values
   // ----------------------------------------------------------------
   localparam logic [1:0] MODE_P2M = 2'h0;
   localparam logic [1:0] MODE_M2P = 2'h1;
   localparam logic [1:0] MODE_M2M = 2'h2;

   localparam int FLAG_DONE_BIT = 0;
   localparam int FLAG_FERR_BIT = 1;

   localparam logic [ADDR_W-1:0] ADDR_STEP = 32'h0000_0004;
   localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;
   localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
   localparam logic [CNT_W-1:0] COUNT_RST = 16'h0000;
   localparam logic [CNT_W-1:0] COUNT_ONE = 16'h0001;
   localparam logic [LVL_W-1:0] LVL_ONE = 3'h1;
   localparam logic [LVL_W-1:0] LVL_FULL = 3'h4;
   localparam logic [LVL_W-1:0] THRESH_RST = 3'h4;
   localparam logic [PTR_W-1:0] PTR_ONE = 2'h1;

   // ----------------------------------------------------------------
   // Stream sequencer states, one-hot
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_RUN = 3'h2,
      ST_DRAIN = 3'h4
   } state_type;

endpackage : dma_stream_pkg

// [rtl/stream_fifo_if.sv]
// Handshake bundle between the stream sequencer and its data FIFO
`timescale 1ns/1ps
interface stream_fifo_if;
   logic push;
   logic [dma_stream_pkg::DATA_W-1:0] push_data;
   logic pop;
   logic [dma_stream_pkg::DATA_W-1:0] pop_data;
   logic flush;
   logic [dma_stream_pkg::LVL_W-1:0] level;
   logic full;
   logic empty;

   modport fifo (input push, push_data, pop, flush,
                 output pop_data, level, full, empty);
   modport user (output push, push_data, pop, flush,
                 input pop_data, level, full, empty);
endinterface : stream_fifo_if

// [rtl/stream_fifo.sv]
// Four-word data FIFO that sits between the two bus ports of a stream
`timescale 1ns/1ps
module stream_fifo (
   input wire logic clk_sys_i,        // system clock
   input wire logic resetn_i,         // async reset, active low
   stream_fifo_if.fifo fifo_port      // push, pop and status
);

   logic [dma_stream_pkg::DATA_W-1:0] mem [dma_stream_pkg::FIFO_DEPTH];
   logic [dma_stream_pkg::PTR_W-1:0] wr_ptr;
   logic [dma_stream_pkg::PTR_W-1:0] rd_ptr;
   logic [dma_stream_pkg::LVL_W-1:0] level;
   logic do_push;
   logic do_pop;

   // Overflow and underflow are dropped, never corrupt the pointers
   assign do_push = fifo_port.push && (level != dma_stream_pkg::LVL_FULL);
   assign do_pop = fifo_port.pop && (level != '0);

   assign fifo_port.pop_data = mem[rd_ptr];
   assign fifo_port.level = level;
   assign fifo_port.full = (level == dma_stream_pkg::LVL_FULL);
   assign fifo_port.empty = (level == '0);

   always_ff @(posedge clk_sys_i) begin
      if (do_push) begin
         mem[wr_ptr] <= fifo_port.push_data;
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         level <= '0;
      end else if (fifo_port.flush) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         level <= '0;
      end else begin
         if (do_push) begin
            wr_ptr <= wr_ptr + dma_stream_pkg::PTR_ONE;
         end
         if (do_pop) begin
            rd_ptr <= rd_ptr + dma_stream_pkg::PTR_ONE;
         end
         if (do_push && !do_pop) begin
            level <= level + dma_stream_pkg::LVL_ONE;
         end else if (do_pop && !do_push) begin
            level <= level - dma_stream_pkg::LVL_ONE;
         end
      end
   end

endmodule : stream_fifo

// [rtl/bus_port.sv]
// One master port: holds a single beat until the slave acknowledges
`timescale 1ns/1ps
module bus_port (
   input wire logic clk_sys_i,                          // system clock
   input wire logic resetn_i,                           // async reset
   input wire logic start_i,                            // launch a beat
   input wire logic write_i,                            // beat direction
   input wire logic [dma_stream_pkg::ADDR_W-1:0] addr_i, // beat address
   input wire logic [dma_stream_pkg::DATA_W-1:0] wdata_i, // write data
   input wire logic ack_i,                              // slave accepts
   input wire logic [dma_stream_pkg::DATA_W-1:0] rdata_i, // slave data
   output logic req_o,                                  // beat pending
   output logic write_o,                                // 1 write
   output logic [dma_stream_pkg::ADDR_W-1:0] addr_o,    // address
   output logic [dma_stream_pkg::DATA_W-1:0] wdata_o,   // write data
   output logic done_o,                                 // beat finished
   output logic [dma_stream_pkg::DATA_W-1:0] rdata_o    // captured data
);

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         req_o <= 1'b0;
         write_o <= 1'b0;
         addr_o <= dma_stream_pkg::ADDR_RST;
         wdata_o <= dma_stream_pkg::DATA_RST;
      end else if (start_i && !req_o) begin
         req_o <= 1'b1;
         write_o <= write_i;
         addr_o <= addr_i;
         wdata_o <= wdata_i;
      end else if (req_o && ack_i) begin
         req_o <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         done_o <= 1'b0;
         rdata_o <= dma_stream_pkg::DATA_RST;
      end else begin
         done_o <= req_o && ack_i;
         if (req_o && ack_i && !write_o) begin
            rdata_o <= rdata_i;
         end
      end
   end

endmodule : bus_port

// [rtl/dma_stream_control.sv]
// Single stream of a dual-port transfer controller: sequencing and flags
`timescale 1ns/1ps

// Behaviour
// - On bit keeps reading 1 after a disable until the stream stopped.
// - Early disable or interruption sets the transfer-done flag.
// - Peripheral request with no prefetched data raises fifo-error flag.
// - Memory-to-memory normal mode sets transfer-done when counter hits 0.
// - Re-enabling a finished memory-to-memory stream reloads last count.
// - Burst with a fixed address locks out other streams.
// - Stopped stream leaves untransferred item count in the counter.
// - Port directions follow the transfer mode.
// - Peripheral port on requests, except M2M where it runs unrequested; memory port on threshold or direct.
// - Memory-to-peripheral prefetches one item or up to four words.
// - Stream owns a four-word FIFO between the two ports.
module dma_stream_control (
   input wire logic clk_sys_i,                        // 40 MHz clock
   input wire logic resetn_i,                         // async, active low
   // stream_config_reg write port
   input wire logic cfg_wr_i,                         // config write
   input wire logic cfg_on_i,                         // on bit value
   input wire logic [1:0] cfg_mode_i,                 // transfer mode
   input wire logic cfg_direct_i,                     // 1 direct mode
   input wire logic [2:0] fifo_threshold_i,           // words, 1 to 4
   input wire logic periph_addr_step_i,               // periph increment
   input wire logic mem_addr_step_i,                  // memory increment
   input wire logic cfg_burst_i,                      // burst beats
   input wire logic [31:0] periph_addr_i,             // periph start addr
   input wire logic [31:0] mem_addr_i,                // memory start addr
   // item_count_reg write port
   input wire logic count_wr_i,                       // count write
   input wire logic [15:0] count_i,                   // items to move
   // low_flag_clear_reg write port
   input wire logic low_flag_clear_wr_i,              // clear write
   input wire logic [1:0] low_flag_clear_i,           // 1 clears a flag
   input wire logic periph_req_i,                     // peripheral request
   // Memory port
   output logic mem_req_o,                            // beat pending
   output logic mem_write_o,                          // 1 write
   output logic [31:0] mem_addr_o,                    // address
   output logic [31:0] mem_wdata_o,                   // write data
   input wire logic mem_ack_i,                        // slave accepts
   input wire logic [31:0] mem_rdata_i,               // read data
   // Peripheral port
   output logic periph_req_o,                         // beat pending
   output logic periph_write_o,                       // 1 write
   output logic [31:0] periph_addr_o,                 // address
   output logic [31:0] periph_wdata_o,                // write data
   input wire logic periph_ack_i,                     // slave accepts
   input wire logic [31:0] periph_rdata_i,            // read data
   // Status
   output logic stream_on_o,                          // on bit readback
   output logic [15:0] remaining_item_counter_o,      // items left
   output logic transfer_done_flag_o,                 // low_status_reg
   output logic fifo_error_flag_o,                    // low_status_reg
   output logic bus_lock_o                            // hold arbitration
);

   // ----------------------------------------------------------------
   // Stream state
   // ----------------------------------------------------------------
   dma_stream_pkg::state_type state;
   logic [1:0] mode;
   logic direct;
   logic [2:0] threshold;
   logic pstep;
   logic mstep;
   logic burst;
   logic [15:0] reload_count;
   logic [15:0] fetch_left;
   logic [31:0] paddr;
   logic [31:0] maddr;

   logic p_done;
   logic m_done;
   logic [31:0] p_rdata;
   logic [31:0] m_rdata;
   logic p_launch;
   logic m_launch;
   logic p_rd;
   logic enable_req;
   logic stop_req;
   logic drained;
   logic [15:0] start_count;
   logic [2:0] m2p_cap;

   stream_fifo_if fifo_bus ();

   stream_fifo u_fifo (
      .clk_sys_i (clk_sys_i),
      .resetn_i (resetn_i),
      .fifo_port (fifo_bus)
   );

   // ----------------------------------------------------------------
   // Launch decisions
   // ----------------------------------------------------------------
   // Peripheral port writes only in M2P
   assign p_rd = (mode != dma_stream_pkg::MODE_M2P);
   assign enable_req = cfg_wr_i && cfg_on_i &&
                       (state == dma_stream_pkg::ST_IDLE);
   assign stop_req = cfg_wr_i && !cfg_on_i &&
                     (state == dma_stream_pkg::ST_RUN);
   assign m2p_cap = direct ? dma_stream_pkg::LVL_ONE :
                    dma_stream_pkg::LVL_FULL;

   // Re-enabling an exhausted M2M stream reuses the last programmed count
   assign start_count =
      (remaining_item_counter_o == dma_stream_pkg::COUNT_RST &&
       cfg_mode_i == dma_stream_pkg::MODE_M2M) ?
      reload_count : remaining_item_counter_o;

   // One peripheral beat at a time
   always_comb begin
      p_launch = 1'b0;
      if (state == dma_stream_pkg::ST_RUN && !periph_req_o && !p_done &&
          remaining_item_counter_o != dma_stream_pkg::COUNT_RST) begin
         if (mode == dma_stream_pkg::MODE_M2M) begin
            p_launch = !fifo_bus.full;
         end else if (mode == dma_stream_pkg::MODE_P2M) begin
            p_launch = periph_req_i && !fifo_bus.full;
         end else begin
            p_launch = periph_req_i && !fifo_bus.empty;
         end
      end
   end

   // Memory port: prefetch in M2P, threshold or direct drain otherwise
   always_comb begin
      m_launch = 1'b0;
      if (!mem_req_o && !m_done) begin
         if (mode == dma_stream_pkg::MODE_M2P) begin
            m_launch = (state == dma_stream_pkg::ST_RUN) &&
                       fetch_left != dma_stream_pkg::COUNT_RST &&
                       fifo_bus.level < m2p_cap;
         end else if (!fifo_bus.empty) begin
            if (direct || state == dma_stream_pkg::ST_DRAIN) begin
               m_launch = 1'b1;
            end else begin
               m_launch = fifo_bus.level >= threshold;
            end
         end
      end
   end

   // Stream may close once no beat is outstanding and the FIFO is empty, except in M2P
   assign drained = !periph_req_o && !mem_req_o && !p_done && !m_done &&
                    (mode == dma_stream_pkg::MODE_M2P || fifo_bus.empty);

   // ----------------------------------------------------------------
   // FIFO connections
   // ----------------------------------------------------------------
   // Prefetched data is discarded when an M2P stream closes
   assign fifo_bus.push = p_rd ? p_done : m_done;
   assign fifo_bus.push_data = p_rd ? p_rdata : m_rdata;
   assign fifo_bus.pop = p_rd ? m_launch : p_launch;
   assign fifo_bus.flush = (state == dma_stream_pkg::ST_DRAIN) && drained &&
                           (mode == dma_stream_pkg::MODE_M2P);

   // ----------------------------------------------------------------
   // Bus ports
   // ----------------------------------------------------------------
   bus_port u_periph_port (
      .clk_sys_i (clk_sys_i),
      .resetn_i (resetn_i),
      .start_i (p_launch),
      .write_i (!p_rd),
      .addr_i (paddr),
      .wdata_i (fifo_bus.pop_data),
      .ack_i (periph_ack_i),
      .rdata_i (periph_rdata_i),
      .req_o (periph_req_o),
      .write_o (periph_write_o),
      .addr_o (periph_addr_o),
      .wdata_o (periph_wdata_o),
      .done_o (p_done),
      .rdata_o (p_rdata)
   );

   bus_port u_mem_port (
      .clk_sys_i (clk_sys_i),
      .resetn_i (resetn_i),
      .start_i (m_launch),
      .write_i (p_rd),
      .addr_i (maddr),
      .wdata_i (fifo_bus.pop_data),
      .ack_i (mem_ack_i),
      .rdata_i (mem_rdata_i),
      .req_o (mem_req_o),
      .write_o (mem_write_o),
      .addr_o (mem_addr_o),
      .wdata_o (mem_wdata_o),
      .done_o (m_done),
      .rdata_o (m_rdata)
   );

   // ----------------------------------------------------------------
   // Sequencer and on bit
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state <= dma_stream_pkg::ST_IDLE;
         stream_on_o <= 1'b0;
      end else begin
         case (state)
            dma_stream_pkg::ST_IDLE: begin
               if (enable_req) begin
                  state <= dma_stream_pkg::ST_RUN;
                  stream_on_o <= 1'b1;
               end
            end
            dma_stream_pkg::ST_RUN: begin
               // Count exhausted or software disable: finish beats first
               if (stop_req || remaining_item_counter_o ==
                   dma_stream_pkg::COUNT_RST) begin
                  state <= dma_stream_pkg::ST_DRAIN;
               end
            end
            dma_stream_pkg::ST_DRAIN: begin
               if (drained) begin
                  state <= dma_stream_pkg::ST_IDLE;
                  stream_on_o <= 1'b0;
               end
            end
            default: begin
               state <= dma_stream_pkg::ST_IDLE;
               stream_on_o <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Configuration, taken only while the stream is off
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mode <= dma_stream_pkg::MODE_P2M;
         direct <= 1'b1;
         threshold <= dma_stream_pkg::THRESH_RST;
         pstep <= 1'b0;
         mstep <= 1'b0;
         burst <= 1'b0;
      end else if (cfg_wr_i && state == dma_stream_pkg::ST_IDLE) begin
         mode <= cfg_mode_i;
         direct <= cfg_direct_i;
         threshold <= fifo_threshold_i;
         pstep <= periph_addr_step_i;
         mstep <= mem_addr_step_i;
         burst <= cfg_burst_i;
      end
   end

   // ----------------------------------------------------------------
   // Item counter; left untouched on a stop so software can resume
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         remaining_item_counter_o <= dma_stream_pkg::COUNT_RST;
         reload_count <= dma_stream_pkg::COUNT_RST;
      end else if (state == dma_stream_pkg::ST_IDLE) begin
         if (count_wr_i) begin
            remaining_item_counter_o <= count_i;
            reload_count <= count_i;
         end else if (enable_req) begin
            remaining_item_counter_o <= start_count;
         end
      end else if (p_done) begin
         remaining_item_counter_o <= remaining_item_counter_o -
                                     dma_stream_pkg::COUNT_ONE;
      end
   end

   // Prefetch budget: M2P never reads past the items still owed
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         fetch_left <= dma_stream_pkg::COUNT_RST;
      end else if (enable_req) begin
         fetch_left <= start_count;
      end else if (m_launch && mode == dma_stream_pkg::MODE_M2P) begin
         fetch_left <= fetch_left - dma_stream_pkg::COUNT_ONE;
      end
   end

   // ----------------------------------------------------------------
   // Addresses, reloaded at every enable so a resume may move them
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         paddr <= dma_stream_pkg::ADDR_RST;
         maddr <= dma_stream_pkg::ADDR_RST;
      end else if (enable_req) begin
         paddr <= periph_addr_i;
         maddr <= mem_addr_i;
      end else begin
         if (p_launch && pstep) begin
            paddr <= paddr + dma_stream_pkg::ADDR_STEP;
         end
         if (m_launch && mstep) begin
            maddr <= maddr + dma_stream_pkg::ADDR_STEP;
         end
      end
   end

   // ----------------------------------------------------------------
   // Flags: a set in the clearing cycle wins
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         transfer_done_flag_o <= 1'b0;
      end else if (state == dma_stream_pkg::ST_DRAIN && drained) begin
         transfer_done_flag_o <= 1'b1;
      end else if (low_flag_clear_wr_i &&
                   low_flag_clear_i[dma_stream_pkg::FLAG_DONE_BIT]) begin
         transfer_done_flag_o <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         fifo_error_flag_o <= 1'b0;
      end else if (state == dma_stream_pkg::ST_RUN &&
                   mode == dma_stream_pkg::MODE_M2P && periph_req_i &&
                   !periph_req_o && !p_done && fifo_bus.empty) begin
         fifo_error_flag_o <= 1'b1;
      end else if (low_flag_clear_wr_i &&
                   low_flag_clear_i[dma_stream_pkg::FLAG_FERR_BIT]) begin
         fifo_error_flag_o <= 1'b0;
      end
   end

   // Fixed-address bursts keep the stream's grant for its whole life
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         bus_lock_o <= 1'b0;
      end else begin
         bus_lock_o <= burst && (!pstep || !mstep) &&
                       (state != dma_stream_pkg::ST_IDLE) &&
                       !(state == dma_stream_pkg::ST_DRAIN && drained);
      end
   end

endmodule : dma_stream_control

// [dv/dma_stream_control_props.sv]
// Port-level assertions of the stream controller
`timescale 1ns/1ps
module dma_stream_control_props (
   input wire logic clk_sys_i, // clock
   input wire logic resetn_i, // reset
   input wire logic [1:0] cfg_mode_i, // mode
   input wire logic cfg_burst_i, // burst
   input wire logic mem_addr_step_i, // step
   input wire logic low_flag_clear_wr_i, // clear strobe
   input wire logic [1:0] low_flag_clear_i, // clear mask
   input wire logic mem_req_o, // mem beat
   input wire logic mem_write_o, // mem dir
   input wire logic periph_req_o, // periph beat
   input wire logic periph_write_o, // periph dir
   input wire logic periph_ack_i, // periph ack
   input wire logic stream_on_o, // on bit
   input wire logic [15:0] remaining_item_counter_o, // count
   input wire logic transfer_done_flag_o, // done
   input wire logic fifo_error_flag_o, // fifo error
   input wire logic bus_lock_o // lock
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);
   wire m2p = cfg_mode_i == dma_stream_pkg::MODE_M2P;
   property p_busy; (mem_req_o || periph_req_o) && stream_on_o |=> stream_on_o;
   endproperty
   a_busy: assert property (p_busy) else $error("on dropped mid beat");
   property p_done; $fell(stream_on_o) |-> transfer_done_flag_o; endproperty
   a_done: assert property (p_done) else $error("close without done");
   property p_dec; periph_req_o && periph_ack_i |-> ##2
      remaining_item_counter_o == $past(remaining_item_counter_o, 2) - 16'h1;
   endproperty
   a_dec: assert property (p_dec) else $error("count not stepped");
   property p_ferr; $rose(fifo_error_flag_o) |-> $past(m2p); endproperty
   a_ferr: assert property (p_ferr) else $error("fifo error off mode");
   property p_clr; low_flag_clear_wr_i && low_flag_clear_i[0] && !stream_on_o
      |=> !transfer_done_flag_o; endproperty
   a_clr: assert property (p_clr) else $error("done not cleared");
   property p_keep; low_flag_clear_wr_i && !low_flag_clear_i[1] &&
      fifo_error_flag_o |=> fifo_error_flag_o; endproperty
   a_keep: assert property (p_keep) else $error("error lost");
   property p_lock; $rose(stream_on_o) && cfg_burst_i && !mem_addr_step_i
      |=> bus_lock_o; endproperty
   a_lock: assert property (p_lock) else $error("no lock");
   property p_pref; $rose(stream_on_o) && m2p |-> ##[0:4] mem_req_o;
   endproperty
   a_pref: assert property (p_pref) else $error("no prefetch");
   property p_dir; mem_req_o |-> mem_write_o == !m2p; endproperty
   a_dir: assert property (p_dir) else $error("mem dir");
   property p_pdir; periph_req_o |-> periph_write_o == m2p; endproperty
   a_pdir: assert property (p_pdir) else $error("periph dir");
   c_m2p: cover property ($rose(fifo_error_flag_o));
   c_lock: cover property (bus_lock_o && stream_on_o);
   c_stop: cover property ($fell(stream_on_o) && remaining_item_counter_o != 0);
endmodule : dma_stream_control_props
bind dma_stream_control dma_stream_control_props u_props (.*);

// [dv/bus_slave_model.sv]
// Bus slave answering one port of the stream controller
`timescale 1ns/1ps
module bus_slave_model #(parameter logic [31:0] BASE = 32'h0) (
   input wire logic clk_sys_i, // clock
   input wire logic resetn_i, // reset
   input wire logic req_i, // beat pending
   input wire logic write_i, // 1 write
   input wire logic [31:0] wdata_i, // write data
   input wire logic slow_i, // add wait states
   output logic ack_o, // accept
   output logic [31:0] rdata_o, // read data
   output logic [31:0] wdata_o, // last write
   output logic [7:0] beats_o // beats seen
);
   logic [1:0] waits;
   // Inverted off-ack data so a stale read never matches
   assign rdata_o = ack_o ? BASE + beats_o : ~(BASE + beats_o);
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ack_o <= 1'b0;
         waits <= 2'h0;
         beats_o <= 8'h0;
         wdata_o <= 32'h0;
      end else begin
         ack_o <= 1'b0;
         if (req_i && !ack_o) begin
            waits <= waits + 2'h1;
            if (!slow_i || waits == 2'h3) ack_o <= 1'b1;
         end
         if (ack_o) begin
            waits <= 2'h0;
            beats_o <= beats_o + 8'h1;
            if (write_i) wdata_o <= wdata_i;
         end
      end
   end
endmodule : bus_slave_model

// [dv/dma_stream_control_bench.sv]
// Self-checking bench of the stream controller
`timescale 1ns/1ps
module dma_stream_control_bench;
   logic clk_sys_i = 0, resetn_i = 0, cfg_wr_i = 0, cfg_on_i = 0;
   logic cfg_direct_i = 1, periph_addr_step_i = 1, mem_addr_step_i = 1;
   logic cfg_burst_i = 0, count_wr_i = 0, low_flag_clear_wr_i = 0;
   logic periph_req_i = 0, slow = 0, mem_ack_i, periph_ack_i;
   logic [1:0] cfg_mode_i = 0, low_flag_clear_i = 0;
   logic [2:0] fifo_threshold_i = 3'h2;
   logic [15:0] count_i = 0, remaining_item_counter_o;
   logic [31:0] periph_addr_i = 32'h100, mem_addr_i = 32'h200;
   logic [31:0] mem_addr_o, mem_wdata_o, mem_rdata_i, mw, pw;
   logic [31:0] periph_addr_o, periph_wdata_o, periph_rdata_i;
   logic mem_req_o, mem_write_o, periph_req_o, periph_write_o, stream_on_o;
   logic transfer_done_flag_o, fifo_error_flag_o, bus_lock_o;
   logic [7:0] mb, pb, m0, p0;
   int n_mismatch = 0, samples_checked = 0, cyc = 0;
   dma_stream_control dut (.*);
   bus_slave_model #(.BASE(32'ha000_0000)) u_mem (.clk_sys_i, .resetn_i,
      .req_i(mem_req_o), .write_i(mem_write_o), .wdata_i(mem_wdata_o),
      .slow_i(slow), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i),
      .wdata_o(mw), .beats_o(mb));
   bus_slave_model #(.BASE(32'hb000_0000)) u_per (.clk_sys_i, .resetn_i,
      .req_i(periph_req_o), .write_i(periph_write_o),
      .wdata_i(periph_wdata_o), .slow_i(slow), .ack_o(periph_ack_i),
      .rdata_o(periph_rdata_i), .wdata_o(pw), .beats_o(pb));
   always #12.5 clk_sys_i = ~clk_sys_i;
   task step(int n = 1); repeat (n) @(posedge clk_sys_i); #1; endtask : step
   task chk(logic [31:0] got, logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task wr_cfg(logic on);
      cfg_on_i = on; cfg_wr_i = 1; step(); cfg_wr_i = 0; step();
   endtask : wr_cfg
   task wr_cnt(logic [15:0] n);
      count_i = n; count_wr_i = 1; step(); count_wr_i = 0; step();
   endtask : wr_cnt
   task clr(logic [1:0] m);
      low_flag_clear_i = m; low_flag_clear_wr_i = 1; step();
      low_flag_clear_wr_i = 0; step();
   endtask : clr
   task wait_off;
      for (int i = 0; i < 300 && stream_on_o !== 1'b0; i++) step();
      chk(stream_on_o, 0);
   endtask : wait_off
   // Request drops after its beat
   task wait_ack;
      for (int i = 0; i < 50 && periph_ack_i !== 1'b1; i++) step();
      step();
   endtask : wait_ack
   task serve; periph_req_i = 1; wait_ack(); periph_req_i = 0; step(3);
   endtask : serve
   task t_p2m;
      m0 = mb; p0 = pb; wr_cnt(3); wr_cfg(1);
      repeat (3) serve();
      wait_off();
      chk(remaining_item_counter_o, 0);
      chk(transfer_done_flag_o, 1);
      chk(mb - m0, 3);
      chk(mw, 32'hb000_0000 + p0 + 2);
   endtask : t_p2m
   task t_stop;
      p0 = pb; clr(3); wr_cnt(5); wr_cfg(1); serve();
      periph_req_i = 1; slow = 1; step(2);
      cfg_on_i = 0; cfg_wr_i = 1; step(); cfg_wr_i = 0;
      chk(stream_on_o, 1);
      wait_ack(); periph_req_i = 0; slow = 0; wait_off();
      chk(remaining_item_counter_o, 3);
      chk(transfer_done_flag_o, 1);
      clr(3); wr_cnt(3); wr_cfg(1); repeat (3) serve(); wait_off();
      chk(mw, 32'hb000_0000 + p0 + 4);
   endtask : t_stop
   task t_m2m;
      p0 = pb; m0 = mb; clr(3); cfg_mode_i = 2; cfg_direct_i = 0;
      cfg_burst_i = 1; mem_addr_step_i = 0; wr_cnt(2); wr_cfg(1);
      chk(bus_lock_o, 1);
      wait_off(); chk(mem_addr_o, 32'h200);
      chk(transfer_done_flag_o, 1);
      chk(mb - m0, 2);
      chk(mw, 32'hb000_0000 + p0 + 1);
      clr(2); chk(transfer_done_flag_o, 1);
      clr(1); chk(transfer_done_flag_o, 0);
      wr_cfg(1); wait_off(); cfg_burst_i = 0; mem_addr_step_i = 1;
      chk(pb - p0, 4);
   endtask : t_m2m
   task t_m2p;
      m0 = mb; clr(3); cfg_mode_i = 1; cfg_direct_i = 1; wr_cnt(2);
      periph_req_i = 1; wr_cfg(1); wait_ack(); periph_req_i = 0; step(3);
      chk(fifo_error_flag_o, 1);
      chk(pw, 32'ha000_0000 + m0);
      serve(); wait_off();
      chk(mb - m0, 2);
      chk(remaining_item_counter_o, 0);
   endtask : t_m2p
   task print_verdict;
      $display("mismatches=%0d checks=%0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : print_verdict
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         print_verdict();
      end
   end
   initial begin
      step(5); resetn_i = 1; step();
      t_p2m(); t_stop(); t_m2m(); t_m2p();
      print_verdict();
   end
endmodule : dma_stream_control_bench
